// ==== slcs_consts.svh ====
`ifndef SLCS_CONSTS_SVH
`define SLCS_CONSTS_SVH

// ****************************************************************************
// Register offsets.
// ****************************************************************************
`define SLCS_OFS_CTRL        8'h00
`define SLCS_OFS_TX_CHAR     8'h04
`define SLCS_OFS_STATUS      8'h08
`define SLCS_OFS_RX_DATA     8'h0C

// ****************************************************************************
// Control register fields.
// ****************************************************************************
`define SLCS_CTRL_PORT_SRC   0
`define SLCS_CTRL_TXOFF_SRC  1
`define SLCS_CTRL_BYPASS     2
`define SLCS_CTRL_DET_POL    3
`define SLCS_CTRL_COMMA_POL  4
`define SLCS_CTRL_W          5

// ****************************************************************************
// Status register fields.
// ****************************************************************************
`define SLCS_STAT_COMMA_FLAG 0
`define SLCS_STAT_LINK       1
`define SLCS_STAT_PORT_SEL   2
`define SLCS_STAT_TX_OFF     3
`define SLCS_STAT_AWAIT      4
`define SLCS_STAT_FRAMED     5

// ****************************************************************************
// Reset values and character codes.
// ****************************************************************************
`define SLCS_CTRL_RST        5'h00
`define SLCS_TX_CHAR_RST     10'h0FA
`define SLCS_COMMA_NEG       10'h0FA
`define SLCS_COMMA_POS       10'h305
`define SLCS_K28_NEG6        6'h0F
`define SLCS_K28_POS6        6'h30
`define SLCS_CHAR_LAST       4'h9
`define SLCS_CLK_HIGH_BITS   4'h5

`endif

// ==== slcs_pkg.sv ====
package slcs_pkg;

  typedef enum logic [2:0] {
    ST_FREE   = 3'h1,
    ST_AWAIT  = 3'h2,
    ST_FRAMED = 3'h4
  } slcs_frame_t;

  typedef logic [9:0] slcs_char_t;

endpackage : slcs_pkg

// ==== slcs_rx_if.sv ====
`timescale 1ns/1ps

interface slcs_rx_if;
  slcs_pkg::slcs_char_t word;
  logic                 comma;
  logic [7:0]           dec_byte;
  logic                 is_k;

  modport dec  (input word, output comma, output dec_byte, output is_k);
  modport core (output word, input comma, input dec_byte, input is_k);
endinterface : slcs_rx_if

// ==== slcs_char_decoder.sv ====
`timescale 1ns/1ps
`include "slcs_consts.svh"

module slcs_char_decoder (
  slcs_rx_if.dec rx
);

  // ****************************************************************************
  // Six-bit to five-bit and four-bit to three-bit tables.
  // ****************************************************************************
  function automatic logic [4:0] slcs_dec6(input logic [5:0] c);
    logic [4:0] r;
    r = 5'h00;
    unique case (c)
      6'h27, 6'h18: r = 5'h00;
      6'h1D, 6'h22: r = 5'h01;
      6'h2D, 6'h12: r = 5'h02;
      6'h31:        r = 5'h03;
      6'h35, 6'h0A: r = 5'h04;
      6'h29:        r = 5'h05;
      6'h19:        r = 5'h06;
      6'h38, 6'h07: r = 5'h07;
      6'h39, 6'h06: r = 5'h08;
      6'h25:        r = 5'h09;
      6'h15:        r = 5'h0A;
      6'h34:        r = 5'h0B;
      6'h0D:        r = 5'h0C;
      6'h2C:        r = 5'h0D;
      6'h1C:        r = 5'h0E;
      6'h17, 6'h28: r = 5'h0F;
      6'h1B, 6'h24: r = 5'h10;
      6'h23:        r = 5'h11;
      6'h13:        r = 5'h12;
      6'h32:        r = 5'h13;
      6'h0B:        r = 5'h14;
      6'h2A:        r = 5'h15;
      6'h1A:        r = 5'h16;
      6'h3A, 6'h05: r = 5'h17;
      6'h33, 6'h0C: r = 5'h18;
      6'h26:        r = 5'h19;
      6'h16:        r = 5'h1A;
      6'h36, 6'h09: r = 5'h1B;
      6'h0E, 6'h0F, 6'h30: r = 5'h1C;
      6'h2E, 6'h11: r = 5'h1D;
      6'h1E, 6'h21: r = 5'h1E;
      6'h2B, 6'h14: r = 5'h1F;
      default:      r = 5'h00;
    endcase
    return r;
  endfunction : slcs_dec6

  function automatic logic [2:0] slcs_dec4(input logic [3:0] c);
    logic [2:0] r;
    r = 3'h0;
    unique case (c)
      4'hB, 4'h4:             r = 3'h0;
      4'h9:                   r = 3'h1;
      4'h5:                   r = 3'h2;
      4'hC, 4'h3:             r = 3'h3;
      4'hD, 4'h2:             r = 3'h4;
      4'hA:                   r = 3'h5;
      4'h6:                   r = 3'h6;
      4'hE, 4'h1, 4'h7, 4'h8: r = 3'h7;
      default:                r = 3'h0;
    endcase
    return r;
  endfunction : slcs_dec4

  // ****************************************************************************
  // Decoder and comma detector.
  // ****************************************************************************
  logic [5:0] six;
  logic [3:0] four;

  assign six  = rx.word[9:4];
  assign four = (six == `SLCS_K28_POS6) ? ~rx.word[3:0] : rx.word[3:0];

  // Both running-disparity forms count as the comma.
  assign rx.comma    = (rx.word == `SLCS_COMMA_NEG) || (rx.word == `SLCS_COMMA_POS);
  assign rx.is_k     = (six == `SLCS_K28_NEG6) || (six == `SLCS_K28_POS6);
  assign rx.dec_byte = {slcs_dec4(four), slcs_dec6(six)};

endmodule : slcs_char_decoder

// ==== slcs_link_ctrl.sv ====
`timescale 1ns/1ps
`include "slcs_consts.svh"

module slcs_link_ctrl #(
  parameter int ADDR_W    = 8,
  parameter int MIN_PULSE = 3
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        OPTICAL_SERIAL_IN,
  input  wire logic        SIGNAL_DETECT,
  input  wire logic        SWITCH_PORT_SELECT,
  input  wire logic        LOOPBACK_SELECT,
  input  wire logic        SWITCH_TX_OFF,
  input  wire logic        LINK_CONTROL,
  input  wire logic        FRAMING_ENABLE,
  output logic             TX_OUT_P,
  output logic             TX_OUT_N,
  output logic             RECOVERED_CHAR_CLOCK,
  output logic [9:0]       RX_DATA,
  output logic             COMMA_FLAG,
  output logic             LINK_STATUS
);

  // ****************************************************************************
  // Parameter checks.
  // ****************************************************************************
  if (ADDR_W < 4 || ADDR_W > 8)
  begin : g_addr_chk
    $error("ADDR_W must be between 4 and 8.");
  end
  if (MIN_PULSE < 1 || MIN_PULSE > 4)
  begin : g_pulse_chk
    $error("MIN_PULSE must be between 1 and 4.");
  end

  localparam logic [2:0] MIN_RUN = 3'(MIN_PULSE - 1);

  // ****************************************************************************
  // Pin synchronisers.
  // ****************************************************************************
  logic [6:0] pin_meta_r;
  logic [6:0] pin_sync_r;
  logic       opt_bit;
  logic       sig_det;
  logic       sw_port;
  logic       conn_port;
  logic       sw_txoff;
  logic       conn_txoff;
  logic       frame_en;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
    begin
      pin_meta_r <= 7'h00;
      pin_sync_r <= 7'h00;
    end
    else
    begin
      pin_meta_r <= {FRAMING_ENABLE, LINK_CONTROL, SWITCH_TX_OFF, LOOPBACK_SELECT,
                     SWITCH_PORT_SELECT, SIGNAL_DETECT, OPTICAL_SERIAL_IN};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign {frame_en, conn_txoff, sw_txoff, conn_port, sw_port, sig_det, opt_bit} = pin_sync_r;

  // ****************************************************************************
  // Register bus.
  // ****************************************************************************
  logic [`SLCS_CTRL_W-1:0] ctrl_r;
  slcs_pkg::slcs_char_t    tx_char_r;
  logic [31:0]             prdata_r;
  logic [31:0]             status;
  logic [7:0]              addr8;
  logic                    mapped;
  logic                    wr_acc;

  assign addr8   = 8'(PADDR);
  assign mapped  = (addr8 == `SLCS_OFS_CTRL) || (addr8 == `SLCS_OFS_TX_CHAR)
                || (addr8 == `SLCS_OFS_STATUS) || (addr8 == `SLCS_OFS_RX_DATA);
  assign wr_acc  = PSEL && PENABLE && PWRITE && mapped;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA  = prdata_r;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
    begin
      ctrl_r    <= `SLCS_CTRL_RST;
      tx_char_r <= `SLCS_TX_CHAR_RST;
    end
    else if (wr_acc)
    begin
      if (addr8 == `SLCS_OFS_CTRL)
        ctrl_r <= PWDATA[`SLCS_CTRL_W-1:0];
      if (addr8 == `SLCS_OFS_TX_CHAR)
        tx_char_r <= PWDATA[9:0];
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
      prdata_r <= 32'h0000_0000;
    else if (PSEL && !PENABLE && !PWRITE)
    begin
      unique case (addr8)
        `SLCS_OFS_CTRL:    prdata_r <= {27'h0000000, ctrl_r};
        `SLCS_OFS_TX_CHAR: prdata_r <= {22'h000000, tx_char_r};
        `SLCS_OFS_STATUS:  prdata_r <= status;
        `SLCS_OFS_RX_DATA: prdata_r <= {22'h000000, RX_DATA};
        default:           prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************************
  // Source selection.
  // ****************************************************************************
  logic port_sel;
  logic tx_off;
  logic bypass;

  assign port_sel = ctrl_r[`SLCS_CTRL_PORT_SRC] ? conn_port : sw_port;
  assign tx_off   = ctrl_r[`SLCS_CTRL_TXOFF_SRC] ? conn_txoff : sw_txoff;
  assign bypass   = ctrl_r[`SLCS_CTRL_BYPASS];

  // ****************************************************************************
  // Transmitter serializer.
  // ****************************************************************************
  logic [3:0] tx_cnt_r;
  logic       tx_bit_r;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
    begin
      tx_cnt_r <= 4'h0;
      tx_bit_r <= 1'b0;
    end
    else
    begin
      tx_cnt_r <= (tx_cnt_r == `SLCS_CHAR_LAST) ? 4'h0 : tx_cnt_r + 4'h1;
      tx_bit_r <= tx_char_r[4'(`SLCS_CHAR_LAST - tx_cnt_r)];
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
    begin
      TX_OUT_P <= 1'b1;
      TX_OUT_N <= 1'b0;
    end
    else if (tx_off)
    begin
      TX_OUT_P <= 1'b1;
      TX_OUT_N <= 1'b0;
    end
    else
    begin
      TX_OUT_P <= tx_bit_r;
      TX_OUT_N <= !tx_bit_r;
    end
  end

  // ****************************************************************************
  // Receiver shifter and framing.
  // ****************************************************************************
  slcs_rx_if rx_if ();

  slcs_char_decoder slcs_char_decoder_inst (
    .rx (rx_if.dec)
  );

  slcs_pkg::slcs_char_t  shift_r;
  slcs_pkg::slcs_char_t  shift_nxt;
  slcs_pkg::slcs_frame_t frame_r;
  logic                  rx_bit;
  logic [3:0]            bit_cnt_r;
  logic                  realign;
  logic                  char_done;
  logic                  frame_en_d_r;
  logic                  char_comma_r;

  assign rx_bit     = port_sel ? opt_bit : tx_bit_r;
  assign shift_nxt  = {shift_r[8:0], rx_bit};
  assign rx_if.word = shift_nxt;
  assign realign    = frame_en && rx_if.comma;
  assign char_done  = (bit_cnt_r == `SLCS_CHAR_LAST) || realign;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
    begin
      shift_r   <= 10'h000;
      bit_cnt_r <= 4'h0;
    end
    else
    begin
      shift_r   <= shift_nxt;
      bit_cnt_r <= char_done ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
    begin
      RX_DATA      <= 10'h000;
      char_comma_r <= 1'b0;
    end
    else if (char_done)
    begin
      RX_DATA      <= bypass ? shift_nxt : {2'h0, rx_if.dec_byte};
      char_comma_r <= rx_if.comma;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
    begin
      frame_r      <= slcs_pkg::ST_FREE;
      frame_en_d_r <= 1'b0;
    end
    else
    begin
      frame_en_d_r <= frame_en;
      unique case (frame_r)
        slcs_pkg::ST_FREE:
          if (frame_en && !frame_en_d_r)
            frame_r <= slcs_pkg::ST_AWAIT;
        slcs_pkg::ST_AWAIT:
          if (!frame_en)
            frame_r <= slcs_pkg::ST_FREE;
          else if (realign)
            frame_r <= slcs_pkg::ST_FRAMED;
        slcs_pkg::ST_FRAMED:
          if (!frame_en)
            frame_r <= slcs_pkg::ST_FREE;
      endcase
    end
  end

  // ****************************************************************************
  // Recovered character clock with pulse stretching.
  // ****************************************************************************
  logic       ckr_want;
  logic [2:0] run_r;

  assign ckr_want = (bit_cnt_r < `SLCS_CLK_HIGH_BITS);

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
    begin
      RECOVERED_CHAR_CLOCK <= 1'b0;
      run_r                <= 3'h0;
    end
    else if (ckr_want != RECOVERED_CHAR_CLOCK && run_r >= MIN_RUN)
    begin
      RECOVERED_CHAR_CLOCK <= ckr_want;
      run_r                <= 3'h0;
    end
    else if (run_r != 3'h7)
      run_r <= run_r + 3'h1;
  end

  // ****************************************************************************
  // Status outputs.
  // ****************************************************************************
  logic comma_active;

  assign comma_active = bypass ? char_comma_r
                               : (char_comma_r || frame_r == slcs_pkg::ST_AWAIT);

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
    begin
      COMMA_FLAG  <= 1'b1;
      LINK_STATUS <= 1'b0;
    end
    else
    begin
      if (bypass)
        COMMA_FLAG <= ctrl_r[`SLCS_CTRL_COMMA_POL] ? comma_active : !comma_active;
      else
        COMMA_FLAG <= ctrl_r[`SLCS_CTRL_COMMA_POL] ? !comma_active : comma_active;
      LINK_STATUS <= ctrl_r[`SLCS_CTRL_DET_POL] ? !sig_det : sig_det;
    end
  end

  assign status = {26'h0000000, frame_r == slcs_pkg::ST_FRAMED, frame_r == slcs_pkg::ST_AWAIT,
                   tx_off, port_sel, LINK_STATUS, COMMA_FLAG};

endmodule : slcs_link_ctrl

// ==== slcs_link_ctrl_props.sv ====
`timescale 1ns/1ps
// ****
// Checker.
// ****
module slcs_link_ctrl_props #(
  parameter int ADDR_W    = 8,
  parameter int MIN_PULSE = 3
) (
  input wire logic              CORE_CLK,
  input wire logic              RESETN,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic              SIGNAL_DETECT,
  input wire logic              SWITCH_TX_OFF,
  input wire logic              LINK_CONTROL,
  input wire logic              TX_OUT_P,
  input wire logic              TX_OUT_N,
  input wire logic              RECOVERED_CHAR_CLOCK,
  input wire logic              COMMA_FLAG,
  input wire logic              LINK_STATUS,
  input wire logic [9:0]        RX_DATA
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  logic [4:0] ctrl_r;
  logic       wr, bp, cp, cm;
  assign wr = PSEL && PENABLE && PWRITE;
  assign bp = ctrl_r[2];
  assign cp = ctrl_r[4];
  assign cm = (RX_DATA == 10'h0FA) || (RX_DATA == 10'h305);
  // Mirrors the control register from the bus writes.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
      ctrl_r <= 5'h00;
    else if (wr && PADDR == '0)
      ctrl_r <= PWDATA[4:0];
  end
  chk_ready_access: assert property (PSEL && PENABLE |-> PREADY) else $error("pready low in access");
  chk_err_unmapped: assert property (PSEL && PENABLE && PADDR > 8'h0C |-> PSLVERR) else $error("no error");
  chk_diff_pair: assert property (TX_OUT_P != TX_OUT_N) else $error("tx pair equal");
  chk_dark_both: assert property ((SWITCH_TX_OFF && LINK_CONTROL)[*8] |-> TX_OUT_P && !TX_OUT_N)
    else $error("tx not dark");
  chk_clk_high: assert property ($rose(RECOVERED_CHAR_CLOCK) |-> RECOVERED_CHAR_CLOCK[*3])
    else $error("short high pulse");
  chk_clk_low: assert property ($fell(RECOVERED_CHAR_CLOCK) |-> (!RECOVERED_CHAR_CLOCK)[*3])
    else $error("short low pulse");
  chk_clk_bound: assert property ($rose(RECOVERED_CHAR_CLOCK) |-> ##[3:16] $fell(RECOVERED_CHAR_CLOCK))
    else $error("char clock stuck high");
  chk_link_hold: assert property (($stable(SIGNAL_DETECT) && !wr)[*8] |-> $stable(LINK_STATUS))
    else $error("link status moved");
  chk_comma_byp: assert property ((bp && cm && !wr)[*4] |-> COMMA_FLAG == cp)
    else $error("comma flag wrong");
  chk_data_byp: assert property ((bp && !cm && !wr && $changed(RX_DATA)) ##1 (bp && !cm && !wr)[*3]
    |-> COMMA_FLAG != cp) else $error("flag on data");
  cover property ($fell(COMMA_FLAG));
  cover property ((TX_OUT_P && !TX_OUT_N)[*8]);
  cover property (PSEL && PENABLE && PSLVERR);
endmodule : slcs_link_ctrl_props

// ==== slcs_optic_model.sv ====
`timescale 1ns/1ps
// ****
// Optical module and fibre.
// ****
module slcs_optic_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tx_p,
  input  wire logic tx_n,
  input  wire logic cut,
  output logic      rx_bit,
  output logic      detect
);
  logic [2:0] run_r;
  logic       noise_r;
  // Counts dark cycles; coded data never runs longer than five.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      run_r <= 3'h7;
    else if (tx_p && !tx_n)
      run_r <= (run_r == 3'h7) ? run_r : run_r + 3'h1;
    else
      run_r <= 3'h0;
  end
  assign detect = !cut && run_r < 3'h6;
  // With no light the line carries noise, never the last bit.
  always_ff @(posedge clk)
  begin
    noise_r <= rst_n ? !noise_r : 1'h0;
    rx_bit  <= detect ? tx_p : noise_r;
  end
endmodule : slcs_optic_model

// ==== test_serial_link_control_status.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
bind slcs_link_ctrl slcs_link_ctrl_props #(.ADDR_W(ADDR_W), .MIN_PULSE(MIN_PULSE)) slcs_link_ctrl_props_inst (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .PADDR(PADDR), .PWDATA(PWDATA), .SIGNAL_DETECT(SIGNAL_DETECT),
  .SWITCH_TX_OFF(SWITCH_TX_OFF), .LINK_CONTROL(LINK_CONTROL), .TX_OUT_P(TX_OUT_P), .TX_OUT_N(TX_OUT_N),
  .RECOVERED_CHAR_CLOCK(RECOVERED_CHAR_CLOCK), .COMMA_FLAG(COMMA_FLAG), .LINK_STATUS(LINK_STATUS), .RX_DATA(RX_DATA));
module test_serial_link_control_status;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] rd; logic err;} slcs_row_t;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, sw_port = 0, lb_sel = 0, sw_off = 0, lctl = 0;
  logic fr_en = 1, cut = 0, pready, pslverr, err, opt_in, sdet, tx_p, tx_n, rclk, flag, lstat, bp, cp;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [9:0] rx_data;
  int failures = 0, comparisons = 0, cnt;
  slcs_row_t rows[9] = '{'{0, 8'h00, 0, 32'h0, 0}, '{0, 8'h04, 0, 32'hFA, 0}, '{1, 8'h00, 32'hFFFFFFFF, 0, 0},
    '{0, 8'h00, 0, 32'h1F, 0}, '{1, 8'h04, 32'hFFFFFFFF, 0, 0}, '{0, 8'h04, 0, 32'h3FF, 0},
    '{1, 8'h10, 32'h1, 0, 1}, '{0, 8'h10, 0, 0, 1}, '{1, 8'h00, 0, 0, 0}};
  logic [9:0] txc[3] = '{10'h0FA, 10'h305, 10'h2AA};
  logic [3:0] pt[4] = '{4'h3, 4'h4, 4'hD, 4'hA};
  logic [3:0] tt[5] = '{4'h5, 4'h2, 4'hB, 4'hC, 4'hF};
  logic [2:0] st[4] = '{3'h1, 3'h4, 3'h2, 3'h7};
  slcs_link_ctrl #(.ADDR_W(8), .MIN_PULSE(3)) slcs_link_ctrl_inst (.CORE_CLK(clk), .RESETN(rst_n),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .OPTICAL_SERIAL_IN(opt_in), .SIGNAL_DETECT(sdet),
    .SWITCH_PORT_SELECT(sw_port), .LOOPBACK_SELECT(lb_sel), .SWITCH_TX_OFF(sw_off), .LINK_CONTROL(lctl),
    .FRAMING_ENABLE(fr_en), .TX_OUT_P(tx_p), .TX_OUT_N(tx_n), .RECOVERED_CHAR_CLOCK(rclk),
    .RX_DATA(rx_data), .COMMA_FLAG(flag), .LINK_STATUS(lstat));
  slcs_optic_model slcs_optic_model_inst (.clk(clk), .rst_n(rst_n), .tx_p(tx_p), .tx_n(tx_n), .cut(cut),
    .rx_bit(opt_in), .detect(sdet));
  // ****
  // Bus and closing tasks.
  // ****
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
  endtask : apb
  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  initial forever #12.5 clk = ~clk;
  initial
  begin
    repeat (6000) @(posedge clk);
    failures++;
    summarize();
  end
  // ****
  // Tests.
  // ****
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      `CHK("pslverr", rows[i].err, err)
      if (!rows[i].w) `CHK("prdata", rows[i].rd, rd)
    end
    $display("test registers done");
    for (int t = 0; t < 3; t++)
      for (int m = 0; m < 4; m++)
      begin
        bp = m[0];
        cp = m[1];
        apb(1'h1, 8'h04, {22'h0, txc[t]});
        apb(1'h1, 8'h00, {27'h0, cp, 1'h0, bp, 2'h0});
        repeat (40) @(posedge clk);
        `CHK("rx_data", bp ? txc[t] : (t == 2 ? 10'h0B5 : 10'h0BC), rx_data)
        `CHK("comma_flag", cp ^ bp ^ (t < 2), flag)
      end
    $display("test modes done");
    apb(1'h1, 8'h04, 32'h0FA);
    cut <= 1;
    foreach (pt[i])
    begin
      apb(1'h1, 8'h00, {29'h0, 1'h1, 1'h0, pt[i][3]});
      sw_port <= pt[i][2];
      lb_sel <= pt[i][1];
      repeat (40) @(posedge clk);
      `CHK("port", pt[i][0], rx_data === 10'h0FA)
    end
    sw_port <= 0;
    cut <= 0;
    $display("test port done");
    foreach (tt[i])
    begin
      apb(1'h1, 8'h00, {30'h0, tt[i][3], 1'h0});
      sw_off <= tt[i][2];
      lctl <= tt[i][1];
      repeat (10) @(posedge clk);
      cnt = 0;
      repeat (10) @(posedge clk) cnt += (tx_p === 1'h1 && tx_n === 1'h0);
      `CHK("dark", tt[i][0], cnt == 10)
    end
    sw_off <= 0;
    lctl <= 0;
    $display("test tx off done");
    foreach (st[i])
    begin
      apb(1'h1, 8'h00, {28'h0, st[i][1], 3'h0});
      cut <= st[i][2];
      repeat (20) @(posedge clk);
      `CHK("link", st[i][0], lstat)
    end
    cut <= 0;
    $display("test detect done");
    apb(1'h1, 8'h00, 32'h0);
    apb(1'h1, 8'h04, 32'h2AA);
    fr_en <= 0;
    repeat (40) @(posedge clk);
    `CHK("flag", 1'h0, flag)
    fr_en <= 1;
    repeat (10) @(posedge clk);
    `CHK("flag", 1'h1, flag)
    apb(1'h0, 8'h08, 32'h0);
    `CHK("await", 1'h1, rd[4])
    apb(1'h1, 8'h04, 32'h0FA);
    repeat (40) @(posedge clk);
    `CHK("flag", 1'h1, flag)
    apb(1'h1, 8'h04, 32'h2AA);
    repeat (40) @(posedge clk);
    `CHK("flag", 1'h0, flag)
    $display("test reframe done");
    fr_en <= 0;
    sw_port <= 1;
    apb(1'h1, 8'h00, 32'h4);
    apb(1'h1, 8'h04, 32'h0FA);
    repeat (40) @(posedge clk);
    `CHK("unframed", 1'h0, rx_data === 10'h0FA)
    fr_en <= 1;
    repeat (40) @(posedge clk);
    `CHK("framed", 10'h0FA, rx_data)
    apb(1'h0, 8'h08, 32'h0);
    `CHK("status", 2'h3, {rd[5], rd[2]})
    apb(1'h0, 8'h0C, 32'h0);
    `CHK("rx_reg", 32'h0FA, rd)
    sw_port <= 0;
    $display("test framing done");
    rst_n <= 0;
    repeat (2) @(posedge clk);
    `CHK("rst", 5'h11, {tx_p, tx_n, rclk, lstat, flag})
    rst_n <= 1;
    apb(1'h0, 8'h00, 32'h0);
    `CHK("ctrl", 32'h0, rd)
    $display("test reset done");
    summarize();
  end
endmodule : test_serial_link_control_status
